// ### phcc_core.sv
// Playfield color generator with hold-and-modify mode and its control registers.
`timescale 1ns/1ps
module phcc_core
   import phcc_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // APB register bus.
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic pready_o,
   output logic [31:0] prdata_o,
   output logic pslverr_o,
   // Pixel stream from the plane shifters.
   input wire logic pix_valid_i,
   input wire logic line_start_i,
   input wire logic blank_i,
   input wire logic [5:0] planes_i,
   // Video outputs.
   output logic [11:0] rgb_o,
   output logic rgb_valid_o,
   output logic gaudio_pin_o,
   output logic ext_sync_o,
   output logic interlace_o,
   output logic burst_o,
   output logic dual_o,
   output logic hires_o,
   output logic [2:0] plane_count_o,
   output logic [3:0] pf1_delay_o,
   output logic [3:0] pf2_delay_o,
   output logic pf2_first_o,
   output logic [5:0] sprite_prio_o,
   output logic [5:0] fetch_begin_o,
   output logic [5:0] fetch_end_o,
   output logic [15:0] win_begin_o,
   output logic [15:0] win_end_o,
   output logic [15:0] odd_mod_o,
   output logic [15:0] even_mod_o,
   output logic [1:0] mode_o
);
   phcc_state_t s_q;
   phcc_state_t s_d;
   logic [2:0] cnt_w;
   logic hold_w;
   logic dual_w;
   logic hires_w;
   logic six_w;
   logic [5:0] pl_w;
   logic [4:0] idx_w;
   phcc_rgb_t sel_w;
   phcc_rgb_t prev_w;
   phcc_rgb_t half_w;
   logic acc_w;
   logic [4:0] creg_w;

   // Decode of the control word fields.
   assign cnt_w = s_q.main_ctrl[PHCC_COUNT_LSB +: 3];
   assign hold_w = s_q.main_ctrl[PHCC_HOLD_BIT];
   assign dual_w = s_q.main_ctrl[PHCC_DUAL_BIT];
   assign hires_w = s_q.main_ctrl[PHCC_HIRES_BIT];
   assign six_w = (cnt_w == PHCC_SIX_PLANES);
   assign acc_w = psel_i && penable_i;
   assign creg_w = paddr_i[6:2]; // Color index within the upper half of the map.

   // Mask planes beyond the enabled count so that absent planes read as zero.
   always_comb
   begin
      for (int i = 0; i < 6; i++)
      begin
         pl_w[i] = planes_i[i] && (3'(i) < cnt_w);
      end
   end

   // Color selection for the current pixel.
   always_comb
   begin
      idx_w = pl_w[4:0];
      if (s_q.mode == PHCC_MODE_HAM)
      begin
         idx_w = {1'b0, pl_w[3:0]};
      end
      sel_w = s_q.colors[12*idx_w +: 12];
      // Line start holds the background color as the left neighbour.
      prev_w = line_start_i ? s_q.colors[11:0] : s_q.pix.rgb;
      half_w = '{red: {1'b0, sel_w.red[3:1]}, green: {1'b0, sel_w.green[3:1]}, blue: {1'b0, sel_w.blue[3:1]}};
   end

   // Next-state logic: register bus, mode decode and pixel path.
   always_comb
   begin
      s_d = s_q;
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      // Mode from the hold, dual, hires and plane count fields of the control word.
      if (hold_w && !dual_w && !hires_w && (cnt_w == PHCC_FIVE_PLANES || six_w))
      begin
         s_d.mode = PHCC_MODE_HAM;
      end
      else if (!hold_w && !dual_w && six_w)
      begin
         s_d.mode = PHCC_MODE_HALF;
      end
      else if (dual_w)
      begin
         s_d.mode = PHCC_MODE_DUAL;
      end
      else
      begin
         s_d.mode = PHCC_MODE_NORMAL;
      end
      // Genlock audio appears on its pin only while blanking.
      s_d.gaudio_pin = blank_i && s_q.main_ctrl[PHCC_GAUDIO_BIT];
      // Pixel generation.
      s_d.pix.valid = pix_valid_i;
      if (pix_valid_i)
      begin
         if (s_q.mode == PHCC_MODE_HAM)
         begin
            s_d.pix.rgb = prev_w;
            case (pl_w[5:4])
               PHCC_SEL_REG: s_d.pix.rgb = sel_w;
               PHCC_SEL_BLUE: s_d.pix.rgb.blue = pl_w[3:0];
               PHCC_SEL_RED: s_d.pix.rgb.red = pl_w[3:0];
               PHCC_SEL_GREEN: s_d.pix.rgb.green = pl_w[3:0];
               default: s_d.pix.rgb = sel_w;
            endcase
         end
         else if (s_q.mode == PHCC_MODE_HALF && pl_w[5])
         begin
            s_d.pix.rgb = half_w;
         end
         else
         begin
            s_d.pix.rgb = sel_w;
         end
      end
      // APB slave, access phase with one wait state (pready registered).
      if (acc_w && !s_q.pready)
      begin
         s_d.pready = 1'b1;
         s_d.prdata = 32'h0000_0000;
         if (pwrite_i)
         begin
            if (paddr_i == PHCC_MAIN_CTRL_ADDR)
            begin
               s_d.main_ctrl = pwdata_i[15:0];
            end
            else if (paddr_i == PHCC_SCROLL_ADDR)
            begin
               s_d.scroll = {8'h00, pwdata_i[7:0]};
            end
            else if (paddr_i == PHCC_PRIO_ADDR)
            begin
               s_d.prio = {9'h000, pwdata_i[6:0]};
            end
            else if (paddr_i == PHCC_FETCH_BEGIN_ADDR)
            begin
               s_d.fetch_begin = {8'h00, pwdata_i[7:2], 2'b00};
            end
            else if (paddr_i == PHCC_FETCH_END_ADDR)
            begin
               s_d.fetch_end = {8'h00, pwdata_i[7:2], 2'b00};
            end
            else if (paddr_i == PHCC_WIN_BEGIN_ADDR)
            begin
               s_d.win_begin = pwdata_i[15:0];
            end
            else if (paddr_i == PHCC_WIN_END_ADDR)
            begin
               s_d.win_end = pwdata_i[15:0];
            end
            else if (paddr_i == PHCC_ODD_MOD_ADDR)
            begin
               s_d.odd_mod = pwdata_i[15:0];
            end
            else if (paddr_i == PHCC_EVEN_MOD_ADDR)
            begin
               s_d.even_mod = pwdata_i[15:0];
            end
            else if (paddr_i >= PHCC_PTR_BASE_ADDR && paddr_i < PHCC_PTR_BASE_ADDR + 8'h30)
            begin
               s_d.ptr[16*(paddr_i[5:2] - 4'h0) +: 16] = pwdata_i[15:0];
            end
            else if (paddr_i >= PHCC_COLOR_BASE_ADDR)
            begin
               s_d.colors[12*creg_w +: 12] = pwdata_i[11:0];
            end
            else
            begin
               s_d.pslverr = 1'b1;
            end
         end
         else if (paddr_i == PHCC_STATUS_ADDR)
         begin
            s_d.prdata = {18'h00000, s_q.pix.rgb, s_q.mode};
         end
         else
         begin
            s_d.pslverr = 1'b1;
         end
      end
   end

   // State register.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register.
   assign rgb_o = s_q.pix.rgb;
   assign rgb_valid_o = s_q.pix.valid;
   assign gaudio_pin_o = s_q.gaudio_pin;
   assign ext_sync_o = s_q.main_ctrl[PHCC_EXT_SYNC_BIT];
   assign interlace_o = s_q.main_ctrl[PHCC_INTERLACE_BIT];
   assign burst_o = s_q.main_ctrl[PHCC_BURST_BIT];
   assign dual_o = dual_w;
   assign hires_o = hires_w;
   assign plane_count_o = cnt_w;
   assign pf1_delay_o = s_q.scroll[3:0];
   assign pf2_delay_o = s_q.scroll[7:4];
   assign pf2_first_o = s_q.prio[PHCC_PF2_FIRST_BIT];
   assign sprite_prio_o = s_q.prio[5:0];
   assign fetch_begin_o = s_q.fetch_begin[7:2];
   assign fetch_end_o = s_q.fetch_end[7:2];
   assign win_begin_o = s_q.win_begin;
   assign win_end_o = s_q.win_end;
   assign odd_mod_o = s_q.odd_mod;
   assign even_mod_o = s_q.even_mod;
   assign mode_o = s_q.mode;
   assign pready_o = s_q.pready;
   assign prdata_o = s_q.prdata;
   assign pslverr_o = s_q.pslverr;

   // Checks on the pixel path, mode decode, audio pin and bus handshake.
   property p_normal_load;
      @(posedge clk_i) disable iff (rst_i)
      (pix_valid_i && s_q.mode == PHCC_MODE_NORMAL) |=> (rgb_o == $past(sel_w));
   endproperty
   a_normal_load: assert property (p_normal_load) else $error("normal pixel color wrong");
   property p_ham_blue;
      @(posedge clk_i) disable iff (rst_i)
      (pix_valid_i && s_q.mode == PHCC_MODE_HAM && pl_w[5:4] == 2'h1)
         |=> (rgb_o[3:0] == $past(pl_w[3:0])) && (rgb_o[11:4] == $past({prev_w.red, prev_w.green}));
   endproperty
   a_ham_blue: assert property (p_ham_blue) else $error("blue modify wrong");
   property p_ham_red;
      @(posedge clk_i) disable iff (rst_i)
      (pix_valid_i && s_q.mode == PHCC_MODE_HAM && pl_w[5:4] == 2'h2)
         |=> (rgb_o[11:8] == $past(pl_w[3:0])) && (rgb_o[7:0] == $past({prev_w.green, prev_w.blue}));
   endproperty
   a_ham_red: assert property (p_ham_red) else $error("red modify wrong");
   property p_ham_green;
      @(posedge clk_i) disable iff (rst_i)
      (pix_valid_i && s_q.mode == PHCC_MODE_HAM && pl_w[5:4] == 2'h3)
         |=> (rgb_o[7:4] == $past(pl_w[3:0])) && (rgb_o[11:8] == $past(prev_w.red))
         && (rgb_o[3:0] == $past(prev_w.blue));
   endproperty
   a_ham_green: assert property (p_ham_green) else $error("green modify wrong");
   property p_ham_enable;
      @(posedge clk_i) disable iff (rst_i)
      (s_q.mode == PHCC_MODE_HAM) == $past(hold_w && !dual_w && !hires_w && (cnt_w == PHCC_FIVE_PLANES || six_w));
   endproperty
   a_ham_enable: assert property (p_ham_enable) else $error("hold mode active wrongly");
   property p_five_planes;
      @(posedge clk_i) disable iff (rst_i)
      (cnt_w == PHCC_FIVE_PLANES) |-> !pl_w[5];
   endproperty
   a_five_planes: assert property (p_five_planes) else $error("sixth plane not zero");
   property p_gaudio;
      @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (gaudio_pin_o == $past(blank_i && s_q.main_ctrl[PHCC_GAUDIO_BIT]));
   endproperty
   a_gaudio: assert property (p_gaudio) else $error("audio bit outside blanking");
   property p_apb_ready;
      @(posedge clk_i) disable iff (rst_i)
      (psel_i && penable_i && !pready_o) |=> pready_o ##1 !pready_o;
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("apb answer timing wrong");
   property p_line_bg;
      @(posedge clk_i) disable iff (rst_i)
      (pix_valid_i && line_start_i && s_q.mode == PHCC_MODE_HAM && pl_w[5:4] == 2'h1)
         |=> rgb_o[11:4] == $past(s_q.colors[11:4]);
   endproperty
   a_line_bg: assert property (p_line_bg) else $error("line start hold wrong");
   c_ham: cover property (@(posedge clk_i) disable iff (rst_i) s_q.mode == PHCC_MODE_HAM && pix_valid_i);
   c_half: cover property (@(posedge clk_i) disable iff (rst_i) s_q.mode == PHCC_MODE_HALF && pix_valid_i);
   c_write: cover property (@(posedge clk_i) disable iff (rst_i) pready_o && !pslverr_o);
endmodule

// ### phcc_enc_model.sv
// Model of the video encoder that takes the pixel stream from the color block.
`timescale 1ns/1ps
module phcc_enc_model
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Pixel stream from the color block.
   input wire logic [11:0] rgb_i,
   input wire logic valid_i,
   // Observation toward the bench.
   output int count_o,
   output logic [11:0] last_o
);
   // Counts the pixels taken and keeps the last color shown on the monitor.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         count_o <= 0;
         last_o <= 12'h000;
      end
      else if (valid_i === 1'b1)
      begin
         count_o <= count_o + 1;
         last_o <= rgb_i;
      end
   end
endmodule

// ### phcc_pkg.sv
// Package with register map, field positions and carrier types of the playfield color block.
package phcc_pkg;
   // Register byte addresses on the APB bus.
   localparam logic [7:0] PHCC_MAIN_CTRL_ADDR = 8'h00;
   localparam logic [7:0] PHCC_SCROLL_ADDR = 8'h04;
   localparam logic [7:0] PHCC_PRIO_ADDR = 8'h08;
   localparam logic [7:0] PHCC_FETCH_BEGIN_ADDR = 8'h0c;
   localparam logic [7:0] PHCC_FETCH_END_ADDR = 8'h10;
   localparam logic [7:0] PHCC_WIN_BEGIN_ADDR = 8'h14;
   localparam logic [7:0] PHCC_WIN_END_ADDR = 8'h18;
   localparam logic [7:0] PHCC_ODD_MOD_ADDR = 8'h1c;
   localparam logic [7:0] PHCC_EVEN_MOD_ADDR = 8'h20;
   localparam logic [7:0] PHCC_STATUS_ADDR = 8'h24;
   localparam logic [7:0] PHCC_PTR_BASE_ADDR = 8'h40;
   localparam logic [7:0] PHCC_COLOR_BASE_ADDR = 8'h80;
   // Field positions in the main control word; PHCC_PF2_FIRST_BIT is in the priority register.
   localparam int PHCC_EXT_SYNC_BIT = 1;
   localparam int PHCC_INTERLACE_BIT = 2;
   localparam int PHCC_GAUDIO_BIT = 8;
   localparam int PHCC_BURST_BIT = 9;
   localparam int PHCC_DUAL_BIT = 10;
   localparam int PHCC_HOLD_BIT = 11;
   localparam int PHCC_COUNT_LSB = 12;
   localparam int PHCC_HIRES_BIT = 15;
   localparam int PHCC_PF2_FIRST_BIT = 6;
   // Plane counts and mode selectors.
   localparam logic [2:0] PHCC_FIVE_PLANES = 3'h5;
   localparam logic [2:0] PHCC_SIX_PLANES = 3'h6;
   localparam logic [2:0] PHCC_NO_PLANES = 3'h0;
   localparam logic [1:0] PHCC_SEL_REG = 2'h0;
   localparam logic [1:0] PHCC_SEL_BLUE = 2'h1;
   localparam logic [1:0] PHCC_SEL_RED = 2'h2;
   localparam logic [1:0] PHCC_SEL_GREEN = 2'h3;
   // Reset values.
   localparam logic [15:0] PHCC_CTRL_RESET = 16'h0000;
   localparam logic [11:0] PHCC_COLOR_RESET = 12'h000;
   // Twelve-bit color split into components.
   typedef struct packed {
      logic [3:0] red;
      logic [3:0] green;
      logic [3:0] blue;
   } phcc_rgb_t;
   // Pixel stream output toward the encoder.
   typedef struct packed {
      phcc_rgb_t rgb;
      logic valid;
   } phcc_pix_t;
   // Decoded mode state.
   typedef enum logic [1:0] {
      PHCC_MODE_NORMAL = 2'b00,
      PHCC_MODE_HAM = 2'b01,
      PHCC_MODE_HALF = 2'b10,
      PHCC_MODE_DUAL = 2'b11
   } phcc_mode_t;
   // All block state.
   typedef struct packed {
      logic [15:0] main_ctrl;
      logic [15:0] scroll;
      logic [15:0] prio;
      logic [15:0] fetch_begin;
      logic [15:0] fetch_end;
      logic [15:0] win_begin;
      logic [15:0] win_end;
      logic [15:0] odd_mod;
      logic [15:0] even_mod;
      logic [191:0] ptr;
      logic [383:0] colors;
      phcc_pix_t pix;
      phcc_mode_t mode;
      logic gaudio_pin;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } phcc_state_t;
endpackage

// ### testbench.sv
// Self-checking bench for the playfield color block with its register bus and encoder model.
`timescale 1ns/1ps
module testbench;
   import phcc_pkg::*;
   logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic pix_valid_i = 0, line_start_i = 0, blank_i = 0, pslverr_o, pready_o, rgb_valid_o;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd_q;
   logic [5:0] planes_i = 6'h00, sprite_prio_o, fetch_begin_o, fetch_end_o, pl[$];
   logic [11:0] rgb_o, enc_last, ex[$];
   logic [15:0] win_begin_o, win_end_o, odd_mod_o, even_mod_o;
   logic [3:0] pf1_delay_o, pf2_delay_o;
   logic [2:0] plane_count_o;
   logic [1:0] mode_o;
   logic gaudio_pin_o, ext_sync_o, interlace_o, burst_o, dual_o, hires_o, pf2_first_o, err_q;
   logic [15:0] cv [6] = '{16'h6000, 16'h6e00, 16'hea00, 16'h4a00, 16'h7a00, 16'h5a00};
   logic [1:0] cm [6] = '{2'h2, 2'h3, 2'h0, 2'h0, 2'h0, 2'h1};
   int err_total = 0, cmp_count = 0, sent = 0, enc_cnt;
   // Design under test with every port connected.
   phcc_core uut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
      .pix_valid_i(pix_valid_i), .line_start_i(line_start_i), .blank_i(blank_i), .planes_i(planes_i),
      .rgb_o(rgb_o), .rgb_valid_o(rgb_valid_o), .gaudio_pin_o(gaudio_pin_o), .ext_sync_o(ext_sync_o),
      .interlace_o(interlace_o), .burst_o(burst_o), .dual_o(dual_o), .hires_o(hires_o),
      .plane_count_o(plane_count_o), .pf1_delay_o(pf1_delay_o), .pf2_delay_o(pf2_delay_o),
      .pf2_first_o(pf2_first_o), .sprite_prio_o(sprite_prio_o), .fetch_begin_o(fetch_begin_o),
      .fetch_end_o(fetch_end_o), .win_begin_o(win_begin_o), .win_end_o(win_end_o), .odd_mod_o(odd_mod_o),
      .even_mod_o(even_mod_o), .mode_o(mode_o));
   // Encoder standing on the far side of the pixel stream.
   phcc_enc_model enc (.clk_i(clk_i), .rst_i(rst_i), .rgb_i(rgb_o), .valid_i(rgb_valid_o),
      .count_o(enc_cnt), .last_o(enc_last));
   // Pixel clock at 25 MHz.
   always #20 clk_i = ~clk_i;
   // Compares one value and counts the outcome.
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One bus transfer: setup, then access held until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= addr;
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (pready_o !== 1'b1 && n < 20);
      rd_q = prdata_o;
      err_q = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (n >= 20)
      begin
         err_total++;
         $display("BAD bus handshake expected pready seen none");
      end
   endtask
   // Writes the whole control word and lets the mode settle.
   task automatic ctrl(input logic [15:0] v);
      apb(1'b1, PHCC_MAIN_CTRL_ADDR, {16'h0000, v});
      @(posedge clk_i);
      @(negedge clk_i);
   endtask
   // Queues one pixel and the color it must produce.
   task automatic px(input logic [5:0] p, input logic [11:0] e);
      pl.push_back(p);
      ex.push_back(e);
   endtask
   // Streams the queued pixels back to back as one line and checks each output color.
   task automatic line_run(input string what);
      for (int i = 0; i <= pl.size(); i++)
      begin
         @(posedge clk_i);
         pix_valid_i <= (i < pl.size());
         line_start_i <= (i == 0);
         planes_i <= (i < pl.size()) ? pl[i] : 6'h00;
         if (i > 0)
         begin
            @(negedge clk_i);
            chk(what, {19'h0, rgb_valid_o, rgb_o}, {19'h0, 1'b1, ex[i-1]});
            sent++;
         end
      end
      pl.delete();
      ex.delete();
      $display("test %s done", what);
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Cuts a hang short.
   initial
   begin
      #(40 * 20000);
      err_total++;
      $display("BAD watchdog expected finish seen timeout");
      final_report;
   end
   // Main sequence of tests.
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk("reset outputs", {rgb_o, mode_o, gaudio_pin_o}, 32'h0);
      apb(1'b1, PHCC_COLOR_BASE_ADDR, 32'h0123);
      apb(1'b1, 8'h94, 32'h0abc);
      apb(1'b1, 8'hcc, 32'h05a5);
      ctrl(16'h6a00);
      chk("mode ham", mode_o, PHCC_MODE_HAM);
      px(6'h1f, 12'h12f);
      px(6'h24, 12'h42f);
      px(6'h37, 12'h47f);
      px(6'h05, 12'habc);
      px(6'h10, 12'hab0);
      line_run("ham line");
      px(6'h29, 12'h923);
      line_run("ham restart");
      apb(1'b0, PHCC_STATUS_ADDR, 32'h0);
      chk("status", {err_q, rd_q[13:0]}, {18'h0, 12'h923, 2'h1});
      ctrl(16'h5800);
      px(6'h25, 12'habc);
      px(6'h3f, 12'habf);
      line_run("five plane ham");
      ctrl(16'h5000);
      px(6'h13, 12'h5a5);
      px(6'h00, 12'h123);
      line_run("normal line");
      ctrl(16'h0000);
      px(6'h3f, 12'h123);
      line_run("background only");
      ctrl(16'h6000);
      px(6'h25, 12'h556);
      px(6'h13, 12'h5a5);
      line_run("half bright line");
      for (int k = 0; k < 6; k++)
      begin
         ctrl(cv[k]);
         chk("mode table", mode_o, cm[k]);
      end
      $display("test mode table done");
      @(posedge clk_i);
      blank_i <= 1'b1;
      ctrl(16'h8706);
      chk("control bits", {hires_o, dual_o, burst_o, interlace_o, ext_sync_o, plane_count_o, gaudio_pin_o},
         32'h1f1);
      @(posedge clk_i);
      blank_i <= 1'b0;
      ctrl(16'h3000);
      chk("control bits clear", {hires_o, dual_o, burst_o, interlace_o, ext_sync_o, plane_count_o, gaudio_pin_o},
         32'h006);
      $display("test control word done");
      apb(1'b1, PHCC_SCROLL_ADDR, 32'h0037);
      apb(1'b1, PHCC_PRIO_ADDR, 32'h0045);
      apb(1'b1, PHCC_FETCH_BEGIN_ADDR, 32'h00d0);
      apb(1'b1, PHCC_FETCH_END_ADDR, 32'h0038);
      apb(1'b1, PHCC_WIN_BEGIN_ADDR, 32'h2c81);
      apb(1'b1, PHCC_WIN_END_ADDR, 32'hf4c1);
      apb(1'b1, PHCC_ODD_MOD_ADDR, 32'h0026);
      apb(1'b1, PHCC_EVEN_MOD_ADDR, 32'hfffe);
      chk("scroll", {pf2_delay_o, pf1_delay_o}, 32'h37);
      chk("priority", {pf2_first_o, sprite_prio_o}, 32'h45);
      chk("fetch", {fetch_begin_o, fetch_end_o}, {20'h0, 6'h34, 6'h0e});
      chk("window", {win_begin_o, win_end_o}, 32'h2c81f4c1);
      chk("modulo", {odd_mod_o, even_mod_o}, 32'h0026fffe);
      apb(1'b1, PHCC_PTR_BASE_ADDR, 32'h0002);
      chk("pointer high", err_q, 1'b0);
      apb(1'b1, PHCC_PTR_BASE_ADDR + 8'h04, 32'h1000);
      chk("pointer low", err_q, 1'b0);
      chk("pointer words", uut.s_q.ptr[31:0], 32'h1000_0002);
      apb(1'b0, PHCC_MAIN_CTRL_ADDR, 32'h0);
      chk("read write-only", err_q, 1'b1);
      apb(1'b0, 8'h28, 32'h0);
      chk("read unmapped", err_q, 1'b1);
      apb(1'b1, PHCC_STATUS_ADDR, 32'h0);
      chk("write status", err_q, 1'b1);
      chk("encoder pixels", enc_cnt, sent);
      $display("test registers done");
      final_report;
   end
endmodule
